// ### src/chan_evt_picker.sv
// Fixed-priority picker: lowest pending channel number wins.
`timescale 1ns/100ps
module chan_evt_picker #(
    parameter int N = 64
) (
    // Pending vector
    input  wire logic [N-1:0]         pend_in,
    // Selection
    output logic                      any_out,
    output logic      [$clog2(N)-1:0] chan_out
);

    function automatic logic [$clog2(N)-1:0] lowest(input logic [N-1:0] v);
        logic [$clog2(N)-1:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = ($clog2(N))'(i);
            end
        end
        return idx;
    endfunction : lowest

    assign any_out  = |pend_in;
    assign chan_out = lowest(pend_in);

endmodule : chan_evt_picker

// ### src/chan_evt_sync.sv
// Two-flop synchroniser with rising-edge detect for external event pins.
`timescale 1ns/100ps
module chan_evt_sync #(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    // Events
    input  wire logic [WIDTH-1:0] evt_async_in,
    output logic      [WIDTH-1:0] evt_rise_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] last_ff;

    // Only sync_ff reads meta_ff; the edge detector looks at later stages.
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end
        else
        begin
            meta_ff <= evt_async_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign evt_rise_out = sync_ff & ~last_ff;

endmodule : chan_evt_sync

// ### src/dma_channel_event_latch.sv
// Event capture, manual set, enable mask and submission offer for 64 DMA channels.
`timescale 1ns/100ps
module dma_channel_event_latch #(
    parameter int NUM_REGIONS = dma_evt_pkg::NUM_REGIONS
) (
    // Clock and reset
    input  wire logic                              clk_sys_in,
    input  wire logic                              reset_in,
    // External event pins
    input  wire logic [dma_evt_pkg::NUM_CHANNELS-1:0] evt_in,
    // Register port
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    input  wire logic [dma_evt_pkg::ADDR_W-1:0]    reg_addr_in,
    input  wire logic                              reg_shadow_in,
    input  wire logic [$clog2(NUM_REGIONS)-1:0]    reg_region_in,
    input  wire logic [dma_evt_pkg::WORD_W-1:0]    reg_wdata_in,
    output logic      [dma_evt_pkg::WORD_W-1:0]    reg_rdata_out,
    output logic                                   reg_rvalid_out,
    // Transfer request offer
    output logic                                   req_valid_out,
    output logic      [5:0]                        req_chan_out,
    input  wire logic                              submit_ack_in,
    // Status
    output logic                                   evt_active_out
);

    localparam int RW = $clog2(NUM_REGIONS);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [63:0]               er_ff;
    logic [63:0]               esr_ff;
    logic [63:0]               en_ff;
    logic [63:0]               miss_ff;
    logic [63:0]               region_acc_ff [NUM_REGIONS];
    logic [31:0]               reg_rdata_ff;
    logic                      reg_rvalid_ff;
    logic [5:0]                req_chan_ff;
    logic                      active_ff;
    logic [63:0]               pend_prev_ff;
    dma_evt_pkg::offer_state_t offer_ff;

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    function automatic logic [63:0] place_word(input logic hi, input logic [31:0] d);
        return hi ? {d, 32'h0} : {32'h0, d};
    endfunction : place_word

    function automatic logic [31:0] pick_word(input logic hi, input logic [63:0] v);
        return hi ? v[63:32] : v[31:0];
    endfunction : pick_word

    wire [4:0]  pair_w     = reg_addr_in[5:1];
    wire        half_w     = reg_addr_in[0];
    wire [63:0] acc_vec_w  = reg_shadow_in ? region_acc_ff[reg_region_in] : '1;
    wire [63:0] wvec_w     = place_word(half_w, reg_wdata_in) & acc_vec_w;
    wire [4:0]  reg_off_w  = pair_w - dma_evt_pkg::PAIR_REGION;
    wire        is_region_w = (pair_w >= dma_evt_pkg::PAIR_REGION)
                            && (reg_off_w < 5'(NUM_REGIONS)) && !reg_shadow_in;
    wire [RW-1:0] region_idx_w = reg_off_w[RW-1:0];

    wire [63:0] sw_clr_w   = (reg_wr_in && pair_w == dma_evt_pkg::PAIR_CLEAR)    ? wvec_w : '0;
    wire [63:0] sw_set_w   = (reg_wr_in && pair_w == dma_evt_pkg::PAIR_SET)      ? wvec_w : '0;
    wire [63:0] en_clr_w   = (reg_wr_in && pair_w == dma_evt_pkg::PAIR_EN_CLR)   ? wvec_w : '0;
    wire [63:0] en_set_w   = (reg_wr_in && pair_w == dma_evt_pkg::PAIR_EN_SET)   ? wvec_w : '0;
    wire [63:0] miss_clr_w = (reg_wr_in && pair_w == dma_evt_pkg::PAIR_MISS_CLR) ? wvec_w : '0;
    wire        en_wr_w    = (en_clr_w | en_set_w) != '0;

    wire [63:0] rd_vec_w =
        (pair_w == dma_evt_pkg::PAIR_LATCH) ? er_ff   :
        (pair_w == dma_evt_pkg::PAIR_SET)   ? esr_ff  :
        (pair_w == dma_evt_pkg::PAIR_EN)    ? en_ff   :
        (pair_w == dma_evt_pkg::PAIR_MISS)  ? miss_ff : '0;
    wire [63:0] rd_mask_w = acc_vec_w;
    wire [31:0] rd_word_w = is_region_w ? pick_word(half_w, region_acc_ff[region_idx_w])
                                        : pick_word(half_w, rd_vec_w & rd_mask_w);

    // ------------------------------------------------------------------
    // Event sources and next state
    // ------------------------------------------------------------------
    logic [63:0] hw_set_w;
    logic        pick_any_w;
    logic [5:0]  pick_chan_w;

    chan_evt_sync #(
        .WIDTH (dma_evt_pkg::NUM_CHANNELS)
    ) u_sync (
        .clk_sys_in   (clk_sys_in),
        .reset_in     (reset_in),
        .evt_async_in (evt_in),
        .evt_rise_out (hw_set_w)
    );

    wire        ack_w      = (offer_ff == dma_evt_pkg::OFFER_WAIT) && submit_ack_in;
    wire [63:0] ack_clr_w  = ack_w ? (64'h1 << req_chan_ff) : '0;
    wire [63:0] er_clr_w   = sw_clr_w | ack_clr_w;
    wire [63:0] clr_only_w = sw_clr_w & ~hw_set_w;

    // Set after clear so a same-cycle event survives either clear.
    wire [63:0] nxt_er   = (er_ff & ~er_clr_w) | hw_set_w;
    wire [63:0] nxt_esr  = (esr_ff & ~ack_clr_w) | sw_set_w;
    wire [63:0] nxt_en   = (en_ff & ~en_clr_w) | en_set_w;
    wire [63:0] miss_hw_w = hw_set_w & er_ff & (en_ff | er_clr_w);
    wire [63:0] miss_sw_w = sw_set_w & esr_ff;
    wire [63:0] nxt_miss = (miss_ff & ~miss_clr_w) | miss_hw_w | miss_sw_w;

    wire [63:0] pend_w   = (er_ff & en_ff) | esr_ff;

    chan_evt_picker #(
        .N (dma_evt_pkg::NUM_CHANNELS)
    ) u_pick (
        .pend_in  (pend_w),
        .any_out  (pick_any_w),
        .chan_out (pick_chan_w)
    );

    // ------------------------------------------------------------------
    // Offer state machine
    // ------------------------------------------------------------------
    dma_evt_pkg::offer_state_t nxt_offer;
    logic [5:0]                nxt_chan;

    always_comb
    begin
        nxt_offer = offer_ff;
        nxt_chan  = req_chan_ff;
        case (offer_ff)
            dma_evt_pkg::OFFER_IDLE:
            begin
                if (pick_any_w)
                begin
                    nxt_offer = dma_evt_pkg::OFFER_WAIT;
                    nxt_chan  = pick_chan_w;
                end
            end
            dma_evt_pkg::OFFER_WAIT:
            begin
                // Withdraw if software cleared the offered channel meanwhile.
                if (submit_ack_in || !pend_w[req_chan_ff])
                begin
                    nxt_offer = dma_evt_pkg::OFFER_IDLE;
                end
            end
            default:
            begin
                nxt_offer = dma_evt_pkg::OFFER_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            er_ff         <= dma_evt_pkg::RESET_BITS;
            esr_ff        <= dma_evt_pkg::RESET_BITS;
            en_ff         <= dma_evt_pkg::RESET_BITS;
            miss_ff       <= dma_evt_pkg::RESET_BITS;
            reg_rdata_ff  <= dma_evt_pkg::RESET_WORD;
            reg_rvalid_ff <= 1'b0;
            req_chan_ff   <= dma_evt_pkg::RESET_CHAN;
            offer_ff      <= dma_evt_pkg::OFFER_IDLE;
            active_ff     <= 1'b0;
            pend_prev_ff  <= dma_evt_pkg::RESET_BITS;
        end
        else
        begin
            er_ff         <= nxt_er;
            esr_ff        <= nxt_esr;
            en_ff         <= nxt_en;
            miss_ff       <= nxt_miss;
            reg_rdata_ff  <= reg_rd_in ? rd_word_w : dma_evt_pkg::RESET_WORD;
            reg_rvalid_ff <= reg_rd_in;
            req_chan_ff   <= nxt_chan;
            offer_ff      <= nxt_offer;
            active_ff     <= |pend_w;
            pend_prev_ff  <= pend_w;
        end
    end

    // Region access masks are written through the global range only.
    for (genvar r = 0; r < NUM_REGIONS; r++)
    begin : g_region
        always_ff @(posedge clk_sys_in)
        begin
            if (reset_in)
            begin
                region_acc_ff[r] <= dma_evt_pkg::RESET_BITS;
            end
            else if (reg_wr_in && is_region_w && region_idx_w == RW'(r))
            begin
                region_acc_ff[r] <= (region_acc_ff[r] & ~place_word(half_w, '1))
                                  | place_word(half_w, reg_wdata_in);
            end
        end
    end

    assign reg_rdata_out  = reg_rdata_ff;
    assign reg_rvalid_out = reg_rvalid_ff;
    assign req_valid_out  = (offer_ff == dma_evt_pkg::OFFER_WAIT);
    assign req_chan_out   = req_chan_ff;
    assign evt_active_out = active_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    AST_LATCH_ALWAYS: assert property (
        (hw_set_w != '0) |=> ((er_ff & $past(hw_set_w)) == $past(hw_set_w)))
        else $error("external event not latched");
    AST_OFFER_PENDING: assert property (
        $rose(req_valid_out) |-> pend_prev_ff[req_chan_out])
        else $error("offered channel was not pending");
    AST_ACK_CLEARS: assert property (
        (ack_w && !hw_set_w[req_chan_ff]) |=> !er_ff[$past(req_chan_ff)])
        else $error("submission did not clear event bit");
    AST_MISS_HW: assert property (
        (miss_hw_w != '0) |=> ((miss_ff & $past(miss_hw_w)) == $past(miss_hw_w)))
        else $error("missed event not flagged");
    AST_SW_CLEAR: assert property (
        (clr_only_w != '0) |=> ((er_ff & $past(clr_only_w)) == '0))
        else $error("software clear failed");
    AST_MANUAL_HOLD: assert property (
        !ack_w |=> ((esr_ff & $past(esr_ff)) == $past(esr_ff)))
        else $error("manual bit lost without submission");
    AST_MANUAL_SET: assert property (
        (sw_set_w != '0) |=> ((esr_ff & $past(sw_set_w)) == $past(sw_set_w)))
        else $error("manual set not taken");
    AST_MISS_SW: assert property (
        (miss_sw_w != '0) |=> ((miss_ff & $past(miss_sw_w)) == $past(miss_sw_w)))
        else $error("repeated manual set not flagged");
    AST_SHADOW_READ: assert property (
        (reg_rd_in && reg_shadow_in) |=> ((reg_rdata_out & ~pick_word($past(half_w),
            $past(rd_mask_w))) == '0))
        else $error("shadow read exposed a foreign channel");
    AST_ENABLE_STABLE: assert property (
        !en_wr_w |=> $stable(en_ff))
        else $error("enable changed without companion write");

    COV_OFFER_ACK: cover property (req_valid_out ##[1:8] submit_ack_in);
    COV_HW_MISS: cover property (miss_hw_w != '0);
    COV_SET_BEATS_ACK: cover property (ack_w && sw_set_w[req_chan_ff]);

endmodule : dma_channel_event_latch

// ### src/dma_evt_pkg.sv
// Shared constants and types for the DMA channel event latch.
package dma_evt_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHANNELS = 64;
    localparam int WORD_W       = 32;
    localparam int ADDR_W       = 6;
    localparam int PAIR_W       = 5;
    localparam int NUM_REGIONS  = 8;

    // ------------------------------------------------------------------
    // Register pairs: word index = {pair, high_half}
    // ------------------------------------------------------------------
    localparam logic [4:0] PAIR_LATCH    = 5'h00;
    localparam logic [4:0] PAIR_CLEAR    = 5'h01;
    localparam logic [4:0] PAIR_SET      = 5'h02;
    localparam logic [4:0] PAIR_EN       = 5'h03;
    localparam logic [4:0] PAIR_EN_CLR   = 5'h04;
    localparam logic [4:0] PAIR_EN_SET   = 5'h05;
    localparam logic [4:0] PAIR_MISS     = 5'h06;
    localparam logic [4:0] PAIR_MISS_CLR = 5'h07;
    localparam logic [4:0] PAIR_REGION   = 5'h08;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [63:0] RESET_BITS = 64'h0;
    localparam logic [31:0] RESET_WORD = 32'h0;
    localparam logic [5:0]  RESET_CHAN = 6'h00;

    typedef enum logic {OFFER_IDLE, OFFER_WAIT} offer_state_t;

endpackage : dma_evt_pkg

// ### testbench/tb.sv
// Self-checking bench for the DMA channel event latch.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
    typedef struct {logic [4:0] wp; logic wh; logic [31:0] wd; logic [4:0] rp; logic rh; logic [31:0] ex;} row_t;
    logic        clk_sys_in = 1'b1;
    logic        reset_in = 1'b1;
    logic [63:0] evt_in = 64'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [5:0]  reg_addr_in = 6'h00;
    logic        reg_shadow_in = 1'b0;
    logic [2:0]  reg_region_in = 3'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic        reg_rvalid_out;
    logic        req_valid_out;
    logic [5:0]  req_chan_out;
    logic        submit_ack_in;
    logic        evt_active_out;
    logic        accept = 1'b0;
    logic [3:0]  delay = 4'h0;
    logic [5:0]  last_chan;
    logic [7:0]  ack_count;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    row_t rows [8] = '{
        '{dma_evt_pkg::PAIR_EN_SET, 1'b0, 32'h0000_00f0, dma_evt_pkg::PAIR_EN, 1'b0, 32'h0000_00f0},
        '{dma_evt_pkg::PAIR_EN_CLR, 1'b0, 32'h0000_0030, dma_evt_pkg::PAIR_EN, 1'b0, 32'h0000_00c0},
        '{dma_evt_pkg::PAIR_EN_CLR, 1'b0, 32'h0000_0000, dma_evt_pkg::PAIR_EN, 1'b0, 32'h0000_00c0},
        '{dma_evt_pkg::PAIR_EN_SET, 1'b1, 32'h8000_0001, dma_evt_pkg::PAIR_EN, 1'b1, 32'h8000_0001},
        '{dma_evt_pkg::PAIR_LATCH, 1'b1, 32'hffff_ffff, dma_evt_pkg::PAIR_LATCH, 1'b1, 32'h0},
        '{5'h09, 1'b0, 32'h0000_00ff, 5'h09, 1'b0, 32'h0000_00ff},
        '{5'h1f, 1'b0, 32'hffff_ffff, 5'h1f, 1'b0, 32'h0},
        '{dma_evt_pkg::PAIR_CLEAR, 1'b0, 32'hffff_ffff, dma_evt_pkg::PAIR_MISS, 1'b0, 32'h0}};

    always #25 clk_sys_in = ~clk_sys_in;

    dma_channel_event_latch i_dma_channel_event_latch (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .evt_in(evt_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_shadow_in(reg_shadow_in), .reg_region_in(reg_region_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .req_valid_out(req_valid_out),
        .req_chan_out(req_chan_out), .submit_ack_in(submit_ack_in),
        .evt_active_out(evt_active_out));

    xfer_ctrl_model i_xfer_ctrl_model (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .accept_in(accept),
        .delay_in(delay), .req_valid_in(req_valid_out), .req_chan_in(req_chan_out),
        .submit_ack_out(submit_ack_in), .last_chan_out(last_chan),
        .ack_count_out(ack_count));

    // -------------------------------------------------------------------------
    // Register access and reporting
    // -------------------------------------------------------------------------
    task automatic wr(input logic [4:0] p, input logic h, input logic [31:0] d,
                      input logic sh = 1'b0, input logic [2:0] rg = 3'h0);
        reg_wr_in = 1'b1;
        reg_addr_in = {p, h};
        reg_wdata_in = d;
        reg_shadow_in = sh;
        reg_region_in = rg;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
        reg_shadow_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] p, input logic h, input logic [31:0] ex,
                      input logic sh = 1'b0, input logic [2:0] rg = 3'h0);
        reg_rd_in = 1'b1;
        reg_addr_in = {p, h};
        reg_shadow_in = sh;
        reg_region_in = rg;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        reg_shadow_in = 1'b0;
        `CHK(reg_rvalid_out, 1'b1)
        `CHK(reg_rdata_out, ex)
    endtask : rd

    task automatic wait_acks(input int n);
        for (int i = 0; i < 60 && ack_count < n; i++)
            @(negedge clk_sys_in);
    endtask : wait_acks

    task automatic end_sim;
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // A hang is cut short well beyond the hundred or so cycles the tests need.
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk_sys_in);
        reset_in = 1'b0;
        foreach (rows[i])
        begin
            wr(rows[i].wp, rows[i].wh, rows[i].wd);
            rd(rows[i].rp, rows[i].rh, rows[i].ex);
        end
        // Disabled channel 2 latches but is never offered.
        evt_in[2] = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        rd(dma_evt_pkg::PAIR_LATCH, 1'b0, 32'h4);
        `CHK(req_valid_out, 1'b0)
        evt_in[6] = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        `CHK(req_valid_out, 1'b1)
        `CHK(req_chan_out, 6'h06)
        `CHK(evt_active_out, 1'b1)
        evt_in[6] = 1'b0;
        evt_in[2] = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        evt_in[6] = 1'b1;
        evt_in[2] = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        rd(dma_evt_pkg::PAIR_MISS, 1'b0, 32'h40);
        wr(dma_evt_pkg::PAIR_CLEAR, 1'b0, 32'h4);
        rd(dma_evt_pkg::PAIR_LATCH, 1'b0, 32'h40);
        `CHK(req_chan_out, 6'h06)
        accept = 1'b1;
        delay = 4'h3;
        wait_acks(1);
        rd(dma_evt_pkg::PAIR_LATCH, 1'b0, 32'h0);
        // Manual sets on channels 0 (through a shadow region) and 63, then served; channel 0 while disabled.
        accept = 1'b0;
        wr(dma_evt_pkg::PAIR_SET, 1'b0, 32'h0000_0101, 1'b1, 3'h1);
        wr(dma_evt_pkg::PAIR_SET, 1'b1, 32'h8000_0000);
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h1);
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h1, 1'b1, 3'h1);
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h0, 1'b1, 3'h2);
        `CHK(req_chan_out, 6'h00)
        wr(dma_evt_pkg::PAIR_SET, 1'b0, 32'h1);
        rd(dma_evt_pkg::PAIR_MISS, 1'b0, 32'h41);
        wr(dma_evt_pkg::PAIR_CLEAR, 1'b0, 32'h1);
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h1);
        accept = 1'b1;
        wait_acks(3);
        `CHK(last_chan, 6'h3f)
        rd(dma_evt_pkg::PAIR_SET, 1'b1, 32'h0);
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h0);
        // A new manual set lands on the very edge of its acknowledge.
        wr(dma_evt_pkg::PAIR_MISS_CLR, 1'b0, 32'hffff_ffff);
        delay = 4'h2;
        wr(dma_evt_pkg::PAIR_SET, 1'b0, 32'h8);
        @(posedge submit_ack_in);
        wr(dma_evt_pkg::PAIR_SET, 1'b0, 32'h8);
        rd(dma_evt_pkg::PAIR_MISS, 1'b0, 32'h8);
        wait_acks(5);
        `CHK(ack_count, 8'h05)
        rd(dma_evt_pkg::PAIR_SET, 1'b0, 32'h0);
        // Reset in mid-run with a manual request pending.
        accept = 1'b0;
        wr(dma_evt_pkg::PAIR_SET, 1'b1, 32'h1);
        reset_in = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        reset_in = 1'b0;
        `CHK(req_valid_out, 1'b0)
        rd(dma_evt_pkg::PAIR_SET, 1'b1, 32'h0);
        rd(dma_evt_pkg::PAIR_EN, 1'b0, 32'h0);
        end_sim();
    end
endmodule : tb

// ### testbench/xfer_ctrl_model.sv
// Behavioural transfer controller that acknowledges offered channels.
`timescale 1ns/100ps
module xfer_ctrl_model (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    // Control from the bench
    input  wire logic       accept_in,
    input  wire logic [3:0] delay_in,
    // Offer from the latch
    input  wire logic       req_valid_in,
    input  wire logic [5:0] req_chan_in,
    output logic            submit_ack_out,
    // Observation
    output logic      [5:0] last_chan_out,
    output logic      [7:0] ack_count_out
);
    logic [3:0] wait_ff;

    // The pulse is launched after the falling edge so it is steady at the sampling edge.
    always @(negedge clk_sys_in)
    begin
        if (reset_in)
        begin
            submit_ack_out <= 1'b0;
            wait_ff        <= 4'h0;
            last_chan_out  <= 6'h00;
            ack_count_out  <= 8'h00;
        end
        else if (submit_ack_out)
            submit_ack_out <= 1'b0;
        else if (req_valid_in && accept_in && wait_ff >= delay_in)
        begin
            submit_ack_out <= 1'b1;
            last_chan_out  <= req_chan_in;
            ack_count_out  <= ack_count_out + 8'h01;
            wait_ff        <= 4'h0;
        end
        else if (req_valid_in && accept_in)
            wait_ff <= wait_ff + 4'h1;
    end
endmodule : xfer_ctrl_model
